// *** rtl/cpg_consts.vh ***
`ifndef CPG_CONSTS_VH
`define CPG_CONSTS_VH

// Register byte offsets on the APB bus.
`define CPG_OFS_CTRL0     8'h00
`define CPG_OFS_CTRL1     8'h04
`define CPG_OFS_CTRL2     8'h08
`define CPG_OFS_CTRL3     8'h0c
`define CPG_OFS_ENABLE    8'h10
`define CPG_OFS_GATE      8'h14
`define CPG_OFS_POLARITY  8'h18
`define CPG_OFS_STATUS    8'h1c
`define CPG_OFS_RELOAD0   8'h20
`define CPG_OFS_RELOAD1   8'h24
`define CPG_OFS_RELOAD2   8'h28
`define CPG_OFS_RELOAD3   8'h2c
`define CPG_OFS_LAST      8'h2c

// Field positions in the per-channel control word.
`define CPG_TRIG_BIT      0
`define CPG_MODE_LO       1
`define CPG_MODE_HI       2
`define CPG_CKS_LO        3
`define CPG_CKS_HI        4
`define CPG_FTS_BIT       5
`define CPG_FLAG_BIT      6
`define CPG_IE_BIT        7

// Operating modes and count clock selects.
`define CPG_MODE_16       2'b10
`define CPG_MODE_1616     2'b11
`define CPG_CKS_DIV1      2'b00
`define CPG_CKS_DIV4      2'b01
`define CPG_CKS_DIV16     2'b10
`define CPG_CKS_DIV64     2'b11

// Reset values.
`define CPG_CTRL_RST      8'h00
`define CPG_ENABLE_RST    4'h0
`define CPG_GATE_RST      2'h0
`define CPG_POLARITY_RST  4'h0
`define CPG_RELOAD_RST    16'h0000

`endif

// *** rtl/cpg_core.v ***
module cpg_core (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        run,
  input  wire        tick,
  input  wire [15:0] low_width,
  input  wire [15:0] high_width,
  output reg         wave_reg,
  output wire        phase_end,
  output wire        end_high
);

  reg        active_reg;
  reg [15:0] cnt_reg;

  // A phase lasts (width + 1) ticks: the count runs down to zero and the
  // tick that finds zero closes the phase.
  assign phase_end = active_reg & run & tick & (cnt_reg == 16'h0000);
  assign end_high  = phase_end & wave_reg;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      active_reg <= 1'b0;
      wave_reg   <= 1'b0;
      cnt_reg    <= 16'h0000;
    end
    else if (!run)
    begin
      active_reg <= 1'b0;
      wave_reg   <= 1'b0;
      cnt_reg    <= 16'h0000;
    end
    else if (!active_reg)
    begin
      // Only the low width is taken at the start, so late reload writes still count.
      active_reg <= 1'b1;
      wave_reg   <= 1'b0;
      cnt_reg    <= low_width;
    end
    else if (tick)
    begin
      if (cnt_reg == 16'h0000)
      begin
        wave_reg <= ~wave_reg;
        cnt_reg  <= wave_reg ? low_width : high_width;
      end
      else
      begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

endmodule

// *** rtl/cpg_top.v ***
// Decided for this implementation: the APB slave port and the address map.
`include "cpg_consts.vh"

module cpg_top (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        timer_gate_in,
  input  wire [1:0]  tg_start,
  output wire        pulse_out_ch0,
  output wire        pulse_out_ch1,
  output wire        pulse_out_ch2,
  output wire        pulse_out_ch3,
  output wire [3:0]  update_irq
);

  reg  [7:0]  ctrl_reg [0:3];
  reg  [15:0] reload_reg [0:3];
  reg  [3:0]  enable_reg;
  reg  [1:0]  gate_sel_reg;
  reg  [3:0]  invert_reg;
  reg  [3:0]  flag_reg;
  reg  [3:0]  flag_next;
  reg  [3:0]  out_reg;
  reg  [5:0]  div_cnt_reg;
  reg         gate_meta_reg;
  reg         gate_sync_reg;
  reg         started_reg;
  reg         started_next;
  reg  [31:0] rd_mux;

  wire        acc;
  wire        hit;
  wire        wr;
  wire [3:0]  wr_idx;
  wire [1:0]  mode0;
  wire [1:0]  mode2;
  wire        mode_1616;
  wire        pair0_16;
  wire        pair2_16;
  wire        req0;
  wire        req2;
  wire        run0;
  wire        run2;
  wire        tick0;
  wire        tick2;
  wire        wave0;
  wire        wave2;
  wire        end0;
  wire        end2;
  wire        end_high0;
  wire        end_high2;
  wire [3:0]  flag_set;
  wire [3:0]  flag_clr;

  integer i;

  // Tick decode from the shared free-running divider.
  function tick_of;
    input [1:0] sel;
    input [5:0] cnt;
    begin
      case (sel)
        `CPG_CKS_DIV1:  tick_of = 1'b1;
        `CPG_CKS_DIV4:  tick_of = (cnt[1:0] == 2'h3);
        `CPG_CKS_DIV16: tick_of = (cnt[3:0] == 4'hf);
        `CPG_CKS_DIV64: tick_of = (cnt == 6'h3f);
        default:        tick_of = 1'b0;
      endcase
    end
  endfunction

  // Start request of a pair: timing generator, timer gate or enable bits.
  function start_of;
    input trig;
    input gate_sel;
    input tg;
    input gate;
    input enables;
    begin
      if (trig)
      begin
        start_of = tg;
      end
      else if (gate_sel)
      begin
        start_of = gate;
      end
      else
      begin
        start_of = enables;
      end
    end
  endfunction

  // The bus answers after one access cycle so read data can come from a flop.
  assign acc     = psel & penable;
  assign hit     = (paddr[1:0] == 2'b00) && (paddr <= `CPG_OFS_LAST);
  assign pready  = acc;
  assign pslverr = acc & ~hit;
  assign wr      = acc & pwrite & hit;
  assign wr_idx  = paddr[5:2];

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
      div_cnt_reg   <= 6'h00;
    end
    else
    begin
      gate_meta_reg <= timer_gate_in;
      gate_sync_reg <= gate_meta_reg;
      div_cnt_reg   <= div_cnt_reg + 6'h01;
    end
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        ctrl_reg[i]   <= `CPG_CTRL_RST;
        reload_reg[i] <= `CPG_RELOAD_RST;
      end
      enable_reg   <= `CPG_ENABLE_RST;
      gate_sel_reg <= `CPG_GATE_RST;
      invert_reg   <= `CPG_POLARITY_RST;
    end
    else if (wr)
    begin
      case (paddr)
        `CPG_OFS_CTRL0, `CPG_OFS_CTRL1, `CPG_OFS_CTRL2, `CPG_OFS_CTRL3:
        begin
          ctrl_reg[wr_idx[1:0]] <= pwdata[7:0];
        end
        `CPG_OFS_ENABLE:
        begin
          enable_reg <= pwdata[3:0];
        end
        `CPG_OFS_GATE:
        begin
          gate_sel_reg <= pwdata[1:0];
        end
        `CPG_OFS_POLARITY:
        begin
          invert_reg <= pwdata[3:0];
        end
        `CPG_OFS_RELOAD0, `CPG_OFS_RELOAD1, `CPG_OFS_RELOAD2, `CPG_OFS_RELOAD3:
        begin
          reload_reg[wr_idx[1:0]] <= pwdata[15:0];
        end
        default:
        begin
          enable_reg <= enable_reg;
        end
      endcase
    end
  end

  assign mode0     = ctrl_reg[0][`CPG_MODE_HI:`CPG_MODE_LO];
  assign mode2     = ctrl_reg[2][`CPG_MODE_HI:`CPG_MODE_LO];
  assign pair0_16  = (mode0 == `CPG_MODE_16);
  assign pair2_16  = (mode2 == `CPG_MODE_16);
  assign mode_1616 = (mode0 == `CPG_MODE_1616) && (mode2 == `CPG_MODE_1616);

  // Enables are ANDed, so a pair runs only once every bit of it is set and
  // stops on the first cleared bit; split writes shift the cycle as warned.
  assign req0 = start_of(ctrl_reg[0][`CPG_TRIG_BIT], gate_sel_reg[0], tg_start[0],
                         gate_sync_reg, enable_reg[0] & enable_reg[1]);
  assign req2 = start_of(ctrl_reg[2][`CPG_TRIG_BIT], gate_sel_reg[1], tg_start[1],
                         gate_sync_reg,
                         mode_1616 ? (&enable_reg) : (enable_reg[2] & enable_reg[3]));

  // Gate start follows the synchronised gate level, so its fall stops the pair.
  assign run2 = (pair2_16 | mode_1616) & req2;
  assign run0 = pair0_16 ? req0 : (mode_1616 & run2 & started_reg);

  // The output side is held back until the first prescaler low phase ends.
  always @*
  begin
    started_next = started_reg;
    if (!(mode_1616 & run2))
    begin
      started_next = 1'b0;
    end
    else if (end2)
    begin
      started_next = 1'b1;
    end
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      started_reg <= 1'b0;
    end
    else
    begin
      started_reg <= started_next;
    end
  end

  // Pair clocks come from the even channel select, but pair 0/1 in 16+16 mode counts prescaler phase ends; the odd one must match.
  assign tick2 = tick_of(ctrl_reg[2][`CPG_CKS_HI:`CPG_CKS_LO], div_cnt_reg);
  assign tick0 = mode_1616 ? end2 :
                 tick_of(ctrl_reg[0][`CPG_CKS_HI:`CPG_CKS_LO], div_cnt_reg);

  // Every prescaler phase end is one edge of its output, hence one output tick.
  cpg_core u_out_pair (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .run        (run0),
    .tick       (tick0),
    .low_width  (reload_reg[1]),
    .high_width (reload_reg[0]),
    .wave_reg   (wave0),
    .phase_end  (end0),
    .end_high   (end_high0)
  );

  cpg_core u_pre_pair (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .run        (run2),
    .tick       (tick2),
    .low_width  (reload_reg[3]),
    .high_width (reload_reg[2]),
    .wave_reg   (wave2),
    .phase_end  (end2),
    .end_high   (end_high2)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_chan
      if (g < 2)
      begin : g_out
        assign flag_set[g] = ctrl_reg[g][`CPG_FTS_BIT] ? end_high0 : end0;
      end
      else
      begin : g_pre
        assign flag_set[g] = ctrl_reg[g][`CPG_FTS_BIT] ? end_high2 : end2;
      end
      assign flag_clr[g]   = wr && (wr_idx == g) && !pwdata[`CPG_FLAG_BIT];
      assign update_irq[g] = flag_reg[g] & ctrl_reg[g][`CPG_IE_BIT];
    end
  endgenerate

  // A flag event in the cycle of a clearing write wins over the clear.
  always @*
  begin
    flag_next = flag_set | (flag_reg & ~flag_clr);
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flag_reg <= 4'h0;
      out_reg  <= 4'h0;
    end
    else
    begin
      flag_reg   <= flag_next;
      out_reg[0] <= wave0 ^ invert_reg[0];
      out_reg[1] <= wave0 ^ invert_reg[1];
      out_reg[2] <= wave2 ^ invert_reg[2];
      out_reg[3] <= wave2 ^ invert_reg[3];
    end
  end

  assign pulse_out_ch0 = out_reg[0];
  assign pulse_out_ch1 = out_reg[1];
  assign pulse_out_ch2 = out_reg[2];
  assign pulse_out_ch3 = out_reg[3];

  always @*
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      `CPG_OFS_CTRL0, `CPG_OFS_CTRL1, `CPG_OFS_CTRL2, `CPG_OFS_CTRL3:
      begin
        rd_mux[7:0] = ctrl_reg[paddr[3:2]];
        rd_mux[`CPG_FLAG_BIT] = flag_reg[paddr[3:2]];
      end
      `CPG_OFS_ENABLE:
      begin
        rd_mux[3:0] = enable_reg;
      end
      `CPG_OFS_GATE:
      begin
        rd_mux[1:0] = gate_sel_reg;
      end
      `CPG_OFS_POLARITY:
      begin
        rd_mux[3:0] = invert_reg;
      end
      `CPG_OFS_STATUS:
      begin
        rd_mux[3:0] = {gate_sync_reg, started_reg, run2, run0};
      end
      `CPG_OFS_RELOAD0, `CPG_OFS_RELOAD1, `CPG_OFS_RELOAD2, `CPG_OFS_RELOAD3:
      begin
        rd_mux[15:0] = reload_reg[paddr[3:2]];
      end
      default:
      begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Read data is captured in the setup cycle and stands through the access.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel && !penable)
    begin
      prdata <= rd_mux;
    end
  end

endmodule

// *** sim/cpg_gate_model.sv ***
module cpg_gate_model (
  input  logic core_clk,
  input  logic resetn,
  input  logic gate_cmd,
  output logic timer_gate_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // The timer moves its gate only just after a clock edge, as a level.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      timer_gate_in <= 1'b0;
    else
      timer_gate_in <= gate_cmd;
  end
endmodule

// *** sim/cpg_top_assertions.sv ***
module cpg_top_assertions (
  input logic        core_clk,
  input logic        resetn,
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        pulse_out_ch0,
  input logic        pulse_out_ch1,
  input logic        pulse_out_ch2,
  input logic        pulse_out_ch3,
  input logic [3:0]  update_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] inv_reg;
  logic [3:0] ie_reg;
  logic [1:0] mode0_reg;
  logic [1:0] mode2_reg;
  logic       acc;
  logic       bad;
  logic       idle0;
  assign acc = psel && penable;
  assign bad = paddr > 8'h2c || paddr[1:0] != 2'b00;
  assign idle0 = mode0_reg != 2'b10 && !(mode0_reg == 2'b11 && mode2_reg == 2'b11);
  // Shadows of the written fields let the pin rules be judged from the ports alone.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      inv_reg <= 4'h0;
      ie_reg <= 4'h0;
      mode0_reg <= 2'h0;
      mode2_reg <= 2'h0;
    end
    else if (acc && pwrite && !bad)
    begin
      if (paddr == 8'h18)
        inv_reg <= pwdata[3:0];
      if (paddr < 8'h10)
        ie_reg[paddr[3:2]] <= pwdata[7];
      if (paddr == 8'h00)
        mode0_reg <= pwdata[2:1];
      if (paddr == 8'h08)
        mode2_reg <= pwdata[2:1];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_read_inv;
    acc && !pwrite && paddr == 8'h18;
  endsequence
  sequence s_idle0;
    idle0 ##1 idle0 ##1 $stable(inv_reg);
  endsequence
  property p_ready;
    acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_quiet;
    !acc |-> !pready && !pslverr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer outside access");
  property p_refuse;
    acc && bad |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad address accepted");
  property p_accept;
    acc && !bad |-> !pslverr;
  endproperty
  a_accept: assert property (p_accept) else $error("good address refused");
  property p_inv_read;
    s_read_inv |-> prdata == {28'h0, inv_reg};
  endproperty
  a_inv_read: assert property (p_inv_read) else $error("polarity read wrong");
  property p_copy;
    inv_reg == 4'h0 |=> pulse_out_ch1 == pulse_out_ch0 && pulse_out_ch3 == pulse_out_ch2;
  endproperty
  a_copy: assert property (p_copy) else $error("odd pin differs");
  property p_idle_pins;
    s_idle0 |-> pulse_out_ch0 == inv_reg[0] && pulse_out_ch1 == inv_reg[1];
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle pin level wrong");
  property p_irq_off;
    (update_irq & ~ie_reg) == 4'h0;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked irq raised");
endmodule

bind cpg_top cpg_top_assertions cpg_top_assertions_i (.core_clk(core_clk), .resetn(resetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_out_ch0(pulse_out_ch0),
  .pulse_out_ch1(pulse_out_ch1), .pulse_out_ch2(pulse_out_ch2),
  .pulse_out_ch3(pulse_out_ch3), .update_irq(update_irq));

// *** sim/cpg_top_bench.sv ***
`include "cpg_consts.vh"
module cpg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        resetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer_gate_in;
  logic        gate_cmd;
  logic [1:0]  tg_start;
  wire  [3:0]  pins;
  logic [3:0]  update_irq;
  logic [31:0] rv;
  logic        ev;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;
  cpg_top cpg_top_i (.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_gate_in(timer_gate_in), .tg_start(tg_start),
    .pulse_out_ch0(pins[0]), .pulse_out_ch1(pins[1]), .pulse_out_ch2(pins[2]),
    .pulse_out_ch3(pins[3]), .update_irq(update_irq));
  cpg_gate_model cpg_gate_model_i (.core_clk(core_clk), .resetn(resetn),
    .gate_cmd(gate_cmd), .timer_gate_in(timer_gate_in));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task wrap_up;
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      fails++;
      wrap_up();
    end
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Every transfer starts on its own rising edge, so back-to-back calls never drive twice.
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask
  task lvl(input int ch, input logic v, output int k);
    k = 0;
    while (pins[ch] === v && k < 400)
    begin
      @(negedge core_clk);
      k++;
    end
  endtask
  task measure(input int ch, output int hi, output int lo);
    int k;
    @(negedge core_clk);
    lvl(ch, 1'b1, k);
    lvl(ch, 1'b0, k);
    lvl(ch, 1'b1, hi);
    lvl(ch, 1'b0, lo);
  endtask
  task t_regs;
    rd(`CPG_OFS_CTRL0);
    chk("ctrl0", 32'h0, rv);
    wr(`CPG_OFS_POLARITY, 32'hf);
    rd(`CPG_OFS_POLARITY);
    chk("polarity", 32'hf, rv);
    repeat (3) @(negedge core_clk);
    chk("idle pins", 32'hf, {28'h0, pins});
    wr(`CPG_OFS_POLARITY, 32'h0);
    rd(8'h30);
    chk("unmapped err", 32'h1, {31'h0, ev});
    chk("unmapped data", 32'h0, rv);
    wr(`CPG_OFS_STATUS, 32'hf);
    rd(`CPG_OFS_STATUS);
    chk("status", 32'h0, rv);
  endtask
  task t_pair(input int src);
    int hi;
    int lo;
    int k;
    wr(`CPG_OFS_CTRL0, (src == 2) ? 32'h0d : 32'h0c);
    wr(`CPG_OFS_CTRL1, 32'h08);
    wr(`CPG_OFS_RELOAD1, 32'h1);
    wr(`CPG_OFS_RELOAD0, 32'h2);
    wr(`CPG_OFS_GATE, (src == 1) ? 32'h1 : 32'h0);
    if (src == 0)
      wr(`CPG_OFS_ENABLE, 32'h3);
    else if (src == 1)
      gate_cmd <= 1'b1;
    else
      tg_start <= 2'b01;
    measure(0, hi, lo);
    chk("pair high", 32'd12, hi);
    chk("pair low", 32'd8, lo);
    chk("pair copy", pins[0], pins[1]);
    rd(`CPG_OFS_CTRL0);
    chk("flag0", 32'h1, rv[6]);
    rd(`CPG_OFS_CTRL1);
    chk("flag1", 32'h1, rv[6]);
    if (src == 0)
      wr(`CPG_OFS_ENABLE, 32'h0);
    else if (src == 1)
      gate_cmd <= 1'b0;
    else
      tg_start <= 2'b00;
    repeat (6) @(negedge core_clk);
    lvl(0, 1'b0, k);
    chk("stopped", 32'd400, k);
    wr(`CPG_OFS_CTRL0, 32'hcc);
    @(negedge core_clk);
    chk("irq on", 32'h1, update_irq[0]);
    wr(`CPG_OFS_CTRL0, 32'h8c);
    @(negedge core_clk);
    chk("irq off", 32'h0, update_irq[0]);
    wr(`CPG_OFS_GATE, 32'h0);
  endtask
  task t_cascade;
    int hi;
    int lo;
    int k;
    wr(`CPG_OFS_CTRL2, 32'h0e);
    wr(`CPG_OFS_CTRL3, 32'h08);
    wr(`CPG_OFS_CTRL0, 32'h1e);
    wr(`CPG_OFS_CTRL1, 32'h18);
    wr(`CPG_OFS_RELOAD3, 32'h1);
    wr(`CPG_OFS_RELOAD2, 32'h1);
    wr(`CPG_OFS_RELOAD1, 32'h1);
    wr(`CPG_OFS_RELOAD0, 32'h5);
    wr(`CPG_OFS_ENABLE, 32'hf);
    wr(`CPG_OFS_RELOAD0, 32'h2);
    measure(2, hi, lo);
    chk("pre high", 32'd8, hi);
    chk("pre low", 32'd8, lo);
    measure(0, hi, lo);
    chk("out high", 32'd24, hi);
    chk("out low", 32'd16, lo);
    rd(`CPG_OFS_CTRL3);
    chk("flag3", 32'h1, rv[6]);
    rd(`CPG_OFS_CTRL1);
    chk("flag1", 32'h1, rv[6]);
    wr(`CPG_OFS_ENABLE, 32'h0);
    repeat (6) @(negedge core_clk);
    lvl(0, 1'b0, k);
    chk("cascade stop", 32'd400, k);
  endtask
  // Pair 2/3 on its own, slow divider, with channel 2 flagging only at high ends.
  task t_pair2;
    int hi;
    int lo;
    int k;
    wr(`CPG_OFS_CTRL2, 32'h34);
    wr(`CPG_OFS_CTRL3, 32'h10);
    wr(`CPG_OFS_RELOAD3, 32'h0);
    wr(`CPG_OFS_RELOAD2, 32'h1);
    wr(`CPG_OFS_ENABLE, 32'hc);
    measure(2, hi, lo);
    chk("pair2 high", 32'd32, hi);
    chk("pair2 low", 32'd16, lo);
    lvl(2, 1'b1, k);
    wr(`CPG_OFS_CTRL2, 32'h34);
    wr(`CPG_OFS_CTRL3, 32'h10);
    lvl(2, 1'b0, k);
    rd(`CPG_OFS_CTRL2);
    chk("flag2 high only", 32'h0, rv[6]);
    rd(`CPG_OFS_CTRL3);
    chk("flag3", 32'h1, rv[6]);
    wr(`CPG_OFS_ENABLE, 32'h0);
    repeat (6) @(negedge core_clk);
    chk("pair2 stop", 32'h0, {28'h0, pins});
  endtask
  initial
  begin
    resetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    gate_cmd = 1'b0;
    tg_start = 2'b00;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_pair(0);
    t_pair(1);
    t_pair(2);
    t_cascade();
    t_pair2();
    wrap_up();
  end
endmodule
